/* File: hw/dcsc_cmd_decoder.sv */
// Command decoder for a dual smart card interface programmed over a serial link.
//
// Functional notes
// - Top three bits address, low five data.
// - Bytes are taken only while chip select low.
// - Async address bits one-zero set card supply.
// - Async address bits three-two set card clock.
// - Sync address drives aux4 and aux8 contacts.
// - Sync address drives clock and data lines.
// - Config bit two low sets detect, mode.
// - Config bit two high, bit zero picks slope.
// - Address 100 decoded without any effect.
// - Async and sync addresses drive selected card reset.
// - Reset contact follows bit four at once.
// - Async commands need bit six matching pin.
// - Bit five picks card A or B.
// - Undefined config codes and don't-cares ignored.
`timescale 1ns/1ps
module dcsc_cmd_decoder (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       spi_sclk,
  input  wire logic       spi_cs_b,
  input  wire logic       spi_mosi,
  input  wire logic       hardware_address_pin,
  input  wire logic       card_clk_in,
  output logic [1:0]      card_a_supply,
  output logic [1:0]      card_b_supply,
  output logic            card_a_clock_out,
  output logic            card_b_clock_out,
  output logic            card_a_data_line_out,
  output logic            card_a_data_line_oe,
  output logic            card_b_data_line_out,
  output logic            card_b_data_line_oe,
  output logic            card_a_aux4_contact,
  output logic            card_b_aux4_contact,
  output logic            card_a_aux8_contact,
  output logic            card_b_aux8_contact,
  output logic            card_a_reset_contact,
  output logic            card_b_reset_contact,
  output logic            card_presence_switch_nc,
  output logic            spi_mode_normal,
  output logic            fast_edge_slope,
  output logic            command_taken
);
  import dcsc_pkg::*;

  // Classifies the address field of a command byte.
  function automatic logic is_async_addr(input logic [2:0] addr);
    return addr[2] == ADDR_ASYNC_TOP;
  endfunction

  // Addresses 110 and 111 carry bits for a synchronous card.
  function automatic logic is_sync_addr(input logic [2:0] addr);
    return addr[2:1] == ADDR_SYNC_TOP;
  endfunction

  // A configuration code is defined unless the selector and bit one are both high.
  function automatic logic cfg_defined(input logic [4:0] data);
    return !data[CFG_SEL_BIT] || !data[VCC_MSB];
  endfunction

  // Byte reception.
  // A byte counts only once all eight bits arrived inside one select frame.
  logic             rx_valid;
  logic [CMD_W-1:0] rx_byte;

  dcsc_spi_rx u_rx (
    .core_clk          (core_clk),
    .rst_b             (rst_b),
    .spi_sclk          (spi_sclk),
    .spi_cs_b          (spi_cs_b),
    .spi_mosi          (spi_mosi),
    .byte_valid        (rx_valid),
    .card_command_byte (rx_byte)
  );

  // Pin synchronisers for the address strap and the card clock source.
  // The clock source runs free, so the dividers use only its settled level (divide by one) and its settled rising edges.
  logic [SYNC_DEPTH-1:0] addr_sync_q;
  logic [SYNC_DEPTH-1:0] ckin_sync_q;
  logic                  addr_lvl_q;
  logic                  addr_lvl_d;
  logic                  ckin_lvl_q;
  logic                  ckin_lvl_d;
  logic                  ckin_rise;

  // A level counts once the second and third stages agree; a lone glitch is dropped.
  always_comb begin
    addr_lvl_d = (addr_sync_q[1] == addr_sync_q[2]) ? addr_sync_q[2] : addr_lvl_q;
    ckin_lvl_d = (ckin_sync_q[1] == ckin_sync_q[2]) ? ckin_sync_q[2] : ckin_lvl_q;
  end

  assign ckin_rise = ckin_lvl_d && !ckin_lvl_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_sync_q <= '0;
      ckin_sync_q <= '0;
      addr_lvl_q  <= 1'b0;
      ckin_lvl_q  <= 1'b0;
    end else begin
      addr_sync_q <= {addr_sync_q[SYNC_DEPTH-2:0], hardware_address_pin};
      ckin_sync_q <= {ckin_sync_q[SYNC_DEPTH-2:0], card_clk_in};
      addr_lvl_q  <= addr_lvl_d;
      ckin_lvl_q  <= ckin_lvl_d;
    end
  end

  // Command fields.
  logic [2:0] cmd_addr;
  logic       cmd_port;
  logic       dev_match;
  logic       async_hit;
  logic       sync_hit;
  logic       cfg_hit;
  logic       cfg_ok;
  logic [4:0] cmd_data;

  assign cmd_addr  = rx_byte[ADDR_MSB:ADDR_LSB];
  assign cmd_data  = rx_byte[RST_BIT:0];
  assign cmd_port  = rx_byte[PORT_BIT];
  // Only asynchronous commands compare bit six with the strap, so two devices that
  // both serve synchronous cards cannot share one chip select.
  assign dev_match = (rx_byte[DEV_BIT] == addr_lvl_q);
  assign async_hit = rx_valid && is_async_addr(cmd_addr) && dev_match;
  assign sync_hit  = rx_valid && is_sync_addr(cmd_addr);
  // Address 100 matches none of the hit terms and so changes nothing.
  assign cfg_hit   = rx_valid && (cmd_addr == ADDR_CFG);
  assign cfg_ok    = cfg_hit && cfg_defined(cmd_data);

  // Per-card state, index 0 is card A and index 1 is card B.
  // Supply, clock and contact settings stay put until a later command for that card.
  logic [1:0]         vcc_q    [2];
  logic [1:0]         vcc_d    [2];
  logic [1:0]         ckdiv_q  [2];
  logic [1:0]         ckdiv_d  [2];
  logic               rst_q    [2];
  logic               rst_d    [2];
  logic               aux4_q   [2];
  logic               aux4_d   [2];
  logic               aux8_q   [2];
  logic               aux8_d   [2];
  logic               sclk_q   [2];
  logic               sclk_d   [2];
  logic               sdat_q   [2];
  logic               sdat_d   [2];
  dcsc_card_mode_type mode_q   [2];
  dcsc_card_mode_type mode_d   [2];
  logic               card_clk [2];
  logic               sync_mode [2];

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_card
      logic selected;
      logic async_sel;
      logic sync_sel;

      // A command reaches only the port picked by bit five; the other port keeps its state.
      assign selected     = (cmd_port == c[0]);
      assign async_sel    = async_hit && selected;
      assign sync_sel     = sync_hit && selected;
      assign sync_mode[c] = (mode_q[c] == DCSC_MODE_SYNC);

      always_comb begin
        vcc_d[c]   = vcc_q[c];
        ckdiv_d[c] = ckdiv_q[c];
        rst_d[c]   = rst_q[c];
        aux4_d[c]  = aux4_q[c];
        aux8_d[c]  = aux8_q[c];
        sclk_d[c]  = sclk_q[c];
        sdat_d[c]  = sdat_q[c];
        mode_d[c]  = mode_q[c];
        if (async_sel) begin
          vcc_d[c]   = rx_byte[VCC_MSB:VCC_LSB];
          ckdiv_d[c] = rx_byte[CLK_MSB:CLK_LSB];
          // Bit four lands on the reset contact as the byte completes, so a host that
          // only sets up the card keeps it low.
          rst_d[c]   = rx_byte[RST_BIT];
          // An asynchronous command returns the clock to the divider and frees the data line.
          mode_d[c]  = DCSC_MODE_ASYNC;
        end else if (sync_sel) begin
          aux4_d[c]  = rx_byte[AUX4_BIT];
          aux8_d[c]  = rx_byte[AUX8_BIT];
          sclk_d[c]  = rx_byte[SCLK_BIT];
          sdat_d[c]  = rx_byte[SDATA_BIT];
          // In synchronous mode bit four is plain card data for the reset contact.
          rst_d[c]   = rx_byte[RST_BIT];
          mode_d[c]  = DCSC_MODE_SYNC;
        end
      end

      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          vcc_q[c]   <= RST_VCC;
          ckdiv_q[c] <= RST_CKDIV;
          rst_q[c]   <= RST_CONTACT;
          aux4_q[c]  <= RST_CONTACT;
          aux8_q[c]  <= RST_CONTACT;
          sclk_q[c]  <= RST_CONTACT;
          sdat_q[c]  <= RST_CONTACT;
          mode_q[c]  <= DCSC_MODE_ASYNC;
        end else begin
          vcc_q[c]   <= vcc_d[c];
          ckdiv_q[c] <= ckdiv_d[c];
          rst_q[c]   <= rst_d[c];
          aux4_q[c]  <= aux4_d[c];
          aux8_q[c]  <= aux8_d[c];
          sclk_q[c]  <= sclk_d[c];
          sdat_q[c]  <= sdat_d[c];
          mode_q[c]  <= mode_d[c];
        end
      end

      // In synchronous mode the clock line follows the commanded bit.
      // Otherwise it divides the settled card clock source by the stored ratio.
      dcsc_clk_div u_div (
        .core_clk     (core_clk),
        .rst_b        (rst_b),
        .clk_level    (ckin_lvl_q),
        .clk_rise     (ckin_rise),
        .div_sel      (ckdiv_q[c]),
        .direct_mode  (sync_mode[c]),
        .direct_level (sclk_q[c]),
        .clock_out    (card_clk[c])
      );
    end
  endgenerate

  // Shared configuration, applied to both cards at once.
  // Detect polarity, sampling mode and slope are only stored for the pads and filter.
  logic det_nc_q;
  logic det_nc_d;
  logic spi_norm_q;
  logic spi_norm_d;
  logic fast_q;
  logic fast_d;
  logic taken_q;
  logic taken_d;

  always_comb begin
    det_nc_d   = det_nc_q;
    spi_norm_d = spi_norm_q;
    fast_d     = fast_q;
    if (cfg_hit) begin
      // Bits four and three are don't-care in this address.
      if (!rx_byte[CFG_SEL_BIT]) begin
        unique case (rx_byte[VCC_MSB:VCC_LSB])
          CFG_DET_NO:      det_nc_d   = 1'b0;
          CFG_DET_NC:      det_nc_d   = 1'b1;
          CFG_SPI_SPECIAL: spi_norm_d = 1'b0;
          CFG_SPI_NORMAL:  spi_norm_d = 1'b1;
        endcase
      end else if (cfg_defined(cmd_data)) begin
        // With the selector high, bit zero picks the slope for both card clocks.
        fast_d = rx_byte[VCC_LSB];
      end
      // Selector high with bit one high is undefined and is dropped.
    end
    // The pulse marks bytes acted on; refused and undefined codes leave it low.
    taken_d = async_hit || sync_hit || cfg_ok;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      det_nc_q   <= RST_DET_NC;
      spi_norm_q <= RST_SPI_NORMAL;
      fast_q     <= RST_FAST_SLOPE;
      taken_q    <= 1'b0;
    end else begin
      det_nc_q   <= det_nc_d;
      spi_norm_q <= spi_norm_d;
      fast_q     <= fast_d;
      taken_q    <= taken_d;
    end
  end

  // Outputs.
  // Supply codes go to the regulators: zero is off, then 1.8 V, 3.0 V and 5.0 V.
  assign card_a_supply           = vcc_q[0];
  assign card_b_supply           = vcc_q[1];
  assign card_a_clock_out        = card_clk[0];
  assign card_b_clock_out        = card_clk[1];
  assign card_a_data_line_out    = sdat_q[0];
  assign card_b_data_line_out    = sdat_q[1];
  // The data line is driven only while its card runs in synchronous mode.
  assign card_a_data_line_oe     = sync_mode[0];
  assign card_b_data_line_oe     = sync_mode[1];
  assign card_a_aux4_contact     = aux4_q[0];
  assign card_b_aux4_contact     = aux4_q[1];
  assign card_a_aux8_contact     = aux8_q[0];
  assign card_b_aux8_contact     = aux8_q[1];
  assign card_a_reset_contact    = rst_q[0];
  assign card_b_reset_contact    = rst_q[1];
  assign card_presence_switch_nc = det_nc_q;
  assign spi_mode_normal         = spi_norm_q;
  assign fast_edge_slope         = fast_q;
  assign command_taken           = taken_q;

endmodule // dcsc_cmd_decoder

/* File: include/dcsc_pkg.sv */
// Shared constants and types for the dual card command decoder.
package dcsc_pkg;

  localparam int unsigned CMD_W       = 8;
  localparam int unsigned SYNC_DEPTH  = 3;
  localparam int unsigned BIT_CNT_W   = 3;

  // Field positions inside the command byte.
  localparam int unsigned ADDR_LSB    = 5;
  localparam int unsigned ADDR_MSB    = 7;
  localparam int unsigned DEV_BIT     = 6;
  localparam int unsigned PORT_BIT    = 5;
  localparam int unsigned RST_BIT     = 4;
  localparam int unsigned CLK_MSB     = 3;
  localparam int unsigned CLK_LSB     = 2;
  localparam int unsigned VCC_MSB     = 1;
  localparam int unsigned VCC_LSB     = 0;
  localparam int unsigned SCLK_BIT    = 3;
  localparam int unsigned SDATA_BIT   = 2;
  localparam int unsigned AUX4_BIT    = 1;
  localparam int unsigned AUX8_BIT    = 0;
  localparam int unsigned CFG_SEL_BIT = 2;

  // Address codes of the three top bits.
  localparam logic [2:0] ADDR_NONE = 3'h4;
  localparam logic [2:0] ADDR_CFG  = 3'h5;
  localparam logic       ADDR_ASYNC_TOP = 1'h0;
  localparam logic [1:0] ADDR_SYNC_TOP  = 2'h3;

  // Supply codes.
  localparam logic [1:0] VCC_OFF  = 2'h0;
  localparam logic [1:0] VCC_1V8  = 2'h1;
  localparam logic [1:0] VCC_3V0  = 2'h2;
  localparam logic [1:0] VCC_5V0  = 2'h3;

  // Card clock selection codes.
  localparam logic [1:0] CKDIV_LOW = 2'h0;
  localparam logic [1:0] CKDIV_1   = 2'h1;
  localparam logic [1:0] CKDIV_2   = 2'h2;
  localparam logic [1:0] CKDIV_4   = 2'h3;

  // Configuration codes with the selector bit low.
  localparam logic [1:0] CFG_DET_NO      = 2'h0;
  localparam logic [1:0] CFG_DET_NC      = 2'h1;
  localparam logic [1:0] CFG_SPI_SPECIAL = 2'h2;
  localparam logic [1:0] CFG_SPI_NORMAL  = 2'h3;

  // Values after reset.
  localparam logic [1:0] RST_VCC        = VCC_OFF;
  localparam logic [1:0] RST_CKDIV      = CKDIV_LOW;
  localparam logic       RST_DET_NC     = 1'h0;
  localparam logic       RST_SPI_NORMAL = 1'h0;
  localparam logic       RST_FAST_SLOPE = 1'h0;
  localparam logic       RST_CONTACT    = 1'h0;

  typedef enum logic [1:0] {
    DCSC_RX_IDLE  = 2'b00,
    DCSC_RX_SHIFT = 2'b01,
    DCSC_RX_DONE  = 2'b11
  } dcsc_rx_state_type;

  typedef enum logic {
    DCSC_MODE_ASYNC = 1'b0,
    DCSC_MODE_SYNC  = 1'b1
  } dcsc_card_mode_type;

endpackage

/* File: hw/dcsc_spi_rx.sv */
// Serial receiver that assembles one command byte per eight clock bits inside a chip select frame.
`timescale 1ns/1ps
module dcsc_spi_rx (
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  input  wire logic                        spi_sclk,
  input  wire logic                        spi_cs_b,
  input  wire logic                        spi_mosi,
  output logic                             byte_valid,
  output logic [dcsc_pkg::CMD_W-1:0]       card_command_byte
);
  import dcsc_pkg::*;

  logic [SYNC_DEPTH-1:0] sync_q [3];
  logic [2:0]            pin_in;
  logic [2:0]            stable_q;
  logic [2:0]            stable_d;

  assign pin_in = {spi_mosi, spi_cs_b, spi_sclk};

  // A pin change is taken once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          // The select chain starts high so that release of reset opens no frame.
          sync_q[g] <= {SYNC_DEPTH{g == 1}};
        end else begin
          sync_q[g] <= {sync_q[g][SYNC_DEPTH-2:0], pin_in[g]};
        end
      end
      always_comb begin
        stable_d[g] = (sync_q[g][1] == sync_q[g][2]) ? sync_q[g][2] : stable_q[g];
      end
    end
  endgenerate

  dcsc_rx_state_type     state_q;
  dcsc_rx_state_type     state_d;
  logic [BIT_CNT_W-1:0]  cnt_q;
  logic [BIT_CNT_W-1:0]  cnt_d;
  logic [CMD_W-1:0]      shift_q;
  logic [CMD_W-1:0]      shift_d;
  logic [CMD_W-1:0]      byte_q;
  logic [CMD_W-1:0]      byte_d;
  logic                  sclk_rise;
  logic                  cs_low;

  assign sclk_rise = stable_d[0] && !stable_q[0];
  assign cs_low    = !stable_d[1];

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    byte_d  = byte_q;
    if (!cs_low) begin
      state_d = DCSC_RX_IDLE;
      cnt_d   = '0;
    end else if (sclk_rise) begin
      shift_d = {shift_q[CMD_W-2:0], stable_d[2]};
      cnt_d   = cnt_q + 3'h1;
      state_d = DCSC_RX_SHIFT;
      if (cnt_q == 3'h7) begin
        byte_d  = {shift_q[CMD_W-2:0], stable_d[2]};
        state_d = DCSC_RX_DONE;
      end
    end else if (state_q == DCSC_RX_DONE) begin
      state_d = DCSC_RX_SHIFT;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stable_q <= 3'h2;
      state_q  <= DCSC_RX_IDLE;
      cnt_q    <= '0;
      shift_q  <= '0;
      byte_q   <= '0;
    end else begin
      stable_q <= stable_d;
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      shift_q  <= shift_d;
      byte_q   <= byte_d;
    end
  end

  assign byte_valid        = (state_q == DCSC_RX_DONE);
  assign card_command_byte = byte_q;

endmodule // dcsc_spi_rx

/* File: hw/dcsc_clk_div.sv */
// Card clock generator: stop, divide by one, two or four, or direct drive.
`timescale 1ns/1ps
module dcsc_clk_div (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_level,
  input  wire logic       clk_rise,
  input  wire logic [1:0] div_sel,
  input  wire logic       direct_mode,
  input  wire logic       direct_level,
  output logic            clock_out
);
  import dcsc_pkg::*;

  logic half_q;
  logic half_d;
  logic out_q;
  logic out_d;

  always_comb begin
    half_d = half_q;
    out_d  = out_q;
    if (direct_mode) begin
      out_d = direct_level;
    end else begin
      unique case (div_sel)
        CKDIV_LOW: out_d = 1'b0;
        CKDIV_1:   out_d = clk_level;
        CKDIV_2:   if (clk_rise) out_d = !out_q;
        CKDIV_4: begin
          if (clk_rise) begin
            half_d = !half_q;
            if (half_q) out_d = !out_q;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_q <= 1'b0;
      out_q  <= 1'b0;
    end else begin
      half_q <= half_d;
      out_q  <= out_d;
    end
  end

  assign clock_out = out_q;

endmodule // dcsc_clk_div

/* File: dv/dcsc_cmd_decoder_sva.sv */
// Port checks for the card command decoder.
`timescale 1ns/1ps
module dcsc_cmd_decoder_chk (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       spi_sclk,
  input wire logic       spi_cs_b,
  input wire logic       spi_mosi,
  input wire logic       hardware_address_pin,
  input wire logic       card_clk_in,
  input wire logic [1:0] card_a_supply,
  input wire logic [1:0] card_b_supply,
  input wire logic       card_a_clock_out,
  input wire logic       card_b_clock_out,
  input wire logic       card_a_data_line_out,
  input wire logic       card_a_data_line_oe,
  input wire logic       card_b_data_line_out,
  input wire logic       card_b_data_line_oe,
  input wire logic       card_a_aux4_contact,
  input wire logic       card_b_aux4_contact,
  input wire logic       card_a_aux8_contact,
  input wire logic       card_b_aux8_contact,
  input wire logic       card_a_reset_contact,
  input wire logic       card_b_reset_contact,
  input wire logic       card_presence_switch_nc,
  input wire logic       spi_mode_normal,
  input wire logic       fast_edge_slope,
  input wire logic       command_taken
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_supply_cause: assert property (
    ($changed(card_a_supply) || $changed(card_b_supply)) |-> command_taken)
    else $error("supply changed without a command");
  a_reset_cause: assert property (
    ($changed(card_a_reset_contact) || $changed(card_b_reset_contact)) |-> command_taken)
    else $error("reset contact changed without a command");
  a_port_single: assert property (
    command_taken |-> !($changed(card_a_supply) && $changed(card_b_supply))
      && !($changed(card_a_reset_contact) && $changed(card_b_reset_contact)))
    else $error("one command changed both card ports");
  a_cfg_cause: assert property (
    ($changed(card_presence_switch_nc) || $changed(spi_mode_normal) || $changed(fast_edge_slope))
      |-> command_taken && $stable(card_a_supply) && $stable(card_b_supply))
    else $error("configuration changed out of turn");
  a_cfg_single: assert property (
    command_taken |-> !($changed(card_presence_switch_nc) && $changed(spi_mode_normal))
      && !($changed(fast_edge_slope) && $changed(spi_mode_normal)))
    else $error("one configuration byte changed two settings");
  a_aux_sync: assert property (
    ($changed(card_a_aux4_contact) || $changed(card_a_aux8_contact))
      |-> command_taken && card_a_data_line_oe)
    else $error("aux contact changed outside a sync command");
  a_oe_cause: assert property (
    ($changed(card_a_data_line_oe) || $changed(card_b_data_line_oe)) |-> command_taken)
    else $error("card mode changed without a command");
  a_sync_clock: assert property (
    (card_a_data_line_oe && $past(card_a_data_line_oe) && $changed(card_a_clock_out))
      || (card_b_data_line_oe && $past(card_b_data_line_oe) && $changed(card_b_clock_out))
      |-> command_taken || $past(command_taken))
    else $error("sync card clock moved without a command");
  a_taken_pulse: assert property (
    command_taken |=> !command_taken [*8])
    else $error("command pulse too long or too frequent");
  a_taken_frame: assert property (
    command_taken |-> $past(spi_cs_b, 5) == 1'b0)
    else $error("command taken outside a select frame");
  a_idle_quiet: assert property (
    spi_cs_b [*8] |-> !command_taken)
    else $error("command taken while deselected");
endmodule // dcsc_cmd_decoder_chk

bind dcsc_cmd_decoder dcsc_cmd_decoder_chk i_chk (.*);

/* File: dv/dcsc_host_model.sv */
// Host controller model that writes command bytes over the serial link.
`timescale 1ns/1ps
module dcsc_host_model (
  input  wire logic core_clk,
  output logic      spi_sclk,
  output logic      spi_cs_b,
  output logic      spi_mosi
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
  end

  // Each level stands four core cycles so the three-stage synchronisers see it.
  task automatic xfer(input logic [7:0] b, input int nbits, input logic keep_cs);
    logic [7:0] d;
    d = b;
    if (d[7] == 1'b0) d[4] = 1'b0;
    @(posedge core_clk);
    spi_cs_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int k = 0; k < nbits; k++) begin
      spi_mosi <= d[7 - k];
      spi_sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
      spi_sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
    spi_sclk <= 1'b0;
    repeat (4) @(posedge core_clk);
    if (!keep_cs) begin
      spi_cs_b <= 1'b1;
      spi_mosi <= ~spi_mosi;
      repeat (4) @(posedge core_clk);
    end
  endtask
endmodule // dcsc_host_model

/* File: dv/dual_card_spi_command_decoder_tb_top.sv */
// Self-checking bench for the dual card command decoder.
`timescale 1ns/1ps
module dual_card_spi_command_decoder_tb_top;
  localparam logic [11:0] CFG [7] = '{12'hb9c, 12'hbbe, 12'hbdf, 12'hbf7, 12'ha0b, 12'ha29,
                                      12'ha48};
  logic       core_clk             = 1'b0;
  logic       rst_b                = 1'b0;
  logic       hardware_address_pin = 1'b0;
  logic [2:0] ck_cnt               = 3'h0;
  wire        card_clk_in          = ck_cnt[2];
  wire        spi_sclk, spi_cs_b, spi_mosi;
  logic [1:0] card_a_supply, card_b_supply, e_sa = 2'h0, e_sb = 2'h0;
  logic       card_a_clock_out, card_b_clock_out, card_a_data_line_out, card_a_data_line_oe;
  logic       card_b_data_line_out, card_b_data_line_oe, card_a_aux4_contact;
  logic       card_b_aux4_contact, card_a_aux8_contact, card_b_aux8_contact;
  logic       card_a_reset_contact, card_b_reset_contact, card_presence_switch_nc;
  logic       spi_mode_normal, fast_edge_slope, command_taken, pa = 1'b0, pb = 1'b0;
  logic       e_oa = 1'b0, e_ob = 1'b0, e_4a = 1'b0, e_4b = 1'b0, e_8a = 1'b0, e_8b = 1'b0;
  logic       e_ra = 1'b0, e_rb = 1'b0, e_nc = 1'b0, e_nm = 1'b0, e_fs = 1'b0;
  int         fails = 0, comparisons = 0, taken_cnt = 0, rise_a = 0, rise_b = 0;
  wire [15:0] obs  = {1'b0, card_a_supply, card_b_supply, card_a_data_line_oe,
                      card_b_data_line_oe, card_a_aux4_contact, card_b_aux4_contact,
                      card_a_aux8_contact, card_b_aux8_contact, card_a_reset_contact,
                      card_b_reset_contact, card_presence_switch_nc, spi_mode_normal,
                      fast_edge_slope};
  wire [15:0] expv = {1'b0, e_sa, e_sb, e_oa, e_ob, e_4a, e_4b, e_8a, e_8b, e_ra, e_rb,
                      e_nc, e_nm, e_fs};

  dcsc_host_model i_host (
    .core_clk(core_clk),
    .spi_sclk(spi_sclk),
    .spi_cs_b(spi_cs_b),
    .spi_mosi(spi_mosi)
  );
  dcsc_cmd_decoder i_dut (.*);

  always #50 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    ck_cnt <= ck_cnt + 3'h1;
    if (command_taken === 1'b1) taken_cnt <= taken_cnt + 1;
    if (card_a_clock_out === 1'b1 && !pa) rise_a <= rise_a + 1;
    if (card_b_clock_out === 1'b1 && !pb) rise_b <= rise_b + 1;
    pa <= card_a_clock_out;
    pb <= card_b_clock_out;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Sends one whole byte, then checks the pulse count and every held output except the clock and data lines.
  task automatic cmd(input logic [7:0] b, input int taken);
    int t0;
    t0 = taken_cnt;
    i_host.xfer(b, 8, 1'b0);
    repeat (2) @(posedge core_clk);
    chk("taken", 16'(taken), 16'(taken_cnt - t0));
    chk("outputs", expv, obs);
  endtask

  initial begin
    int ra;
    int rb;
    int ex;
    int t0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge core_clk);
    #1;
    chk("reset", 16'h0, obs);
    chk("reset_clk", 16'h0, {14'h0, card_a_clock_out, card_b_clock_out});
    $display("end reset");
    for (int v = 0; v < 4; v++) begin
      e_sa = 2'(v);
      cmd({6'h00, 2'(v)}, 1);
    end
    e_sb = 2'h3;
    cmd(8'h23, 1);
    $display("end supply");
    cmd(8'h42, 0);
    hardware_address_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    e_sa = 2'h1;
    cmd(8'h41, 1);
    cmd(8'h02, 0);
    hardware_address_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
    $display("end strap");
    for (int c = 0; c < 4; c++) begin
      cmd({4'h0, 2'(c), 2'h1}, 1);
      ra = rise_a;
      rb = rise_b;
      repeat (128) @(posedge core_clk);
      #1;
      ex = (c == 0) ? 0 : (32 >> c);
      chk("rises_a", 16'h1, 16'((rise_a - ra + 1 >= ex) && (rise_a - ra <= ex + 1)
          && (c > 0 || rise_a == ra)));
      chk("rises_b", 16'h0, 16'(rise_b - rb));
    end
    $display("end clock");
    t0 = taken_cnt;
    i_host.xfer(8'hff, 5, 1'b0);
    chk("partial", 16'h0, 16'(taken_cnt - t0));
    e_sa = 2'h2;
    cmd(8'h02, 1);
    t0 = taken_cnt;
    i_host.xfer(8'h21, 8, 1'b1);
    e_sb = 2'h1;
    e_sa = 2'h3;
    cmd(8'h03, 1);
    chk("frame", 16'h2, 16'(taken_cnt - t0));
    $display("end framing");
    for (int i = 0; i < 7; i++) begin
      {e_nc, e_nm, e_fs} = CFG[i][2:0];
      cmd(CFG[i][11:4], int'(CFG[i][3]));
    end
    cmd(8'h9f, 0);
    $display("end config");
    {e_ra, e_oa, e_4a} = 3'h7;
    cmd(8'hde, 1);
    chk("sync_a", 16'h3, {14'h0, card_a_clock_out, card_a_data_line_out});
    {e_ob, e_8b} = 2'h3;
    cmd(8'he5, 1);
    chk("sync_b", 16'h1, {14'h0, card_b_clock_out, card_b_data_line_out});
    {e_ra, e_4a, e_8a} = 3'h1;
    cmd(8'hc9, 1);
    chk("sync_a2", 16'h2, {14'h0, card_a_clock_out, card_a_data_line_out});
    $display("end sync");
    finish_test();
  end
endmodule // dual_card_spi_command_decoder_tb_top
